// ==== csm_monitor.sv ====
// Purpose: Port checks for the clock source select block
// Assumes: Source clocks hold each phase for two CORE_CLK cycles
// Notes:   Which source a mux follows is judged by the testbench
`timescale 1ns/10ps
module csm_monitor
(
   input wire logic       CORE_CLK,
   input wire logic       RST_B,
   input wire logic [7:0] REG_ADDR,
   input wire logic       REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic       PREDIV_INPUT_CLOCK,
   input wire logic       PRIMARY_PORT_BITCLK_DIV_CLK,
   input wire logic       ANALOG_RATIO_DIVIDER_CLK
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   unmapped_zero_a: assert property (!(REG_ADDR inside {[8'h32:8'h34]})
      |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
   pri_reserved_a: assert property (REG_ADDR == 8'h32
      |=> REG_RDATA[2:0] == 3'h0) else $error("reserved bits set");
   sec_reserved_a: assert property (REG_ADDR == 8'h33
      |=> (REG_RDATA & 8'h8f) == 8'h00) else $error("reserved bits set");
   cnv_reserved_a: assert property (REG_ADDR == 8'h34
      |=> REG_RDATA[3:0] == 4'h0) else $error("reserved bits set");
   cnv_write_back_a: assert property ((REG_WR && REG_ADDR == 8'h34)
      ##1 (!REG_WR && REG_ADDR == 8'h34) |=> REG_RDATA ==
      ($past(REG_WDATA, 2) & 8'hf0)) else $error("bad readback");
   pri_write_back_a: assert property ((REG_WR && REG_ADDR == 8'h32)
      ##1 (!REG_WR && REG_ADDR == 8'h32) |=> REG_RDATA ==
      ($past(REG_WDATA, 2) & 8'hf8)) else $error("bad readback");
   prediv_no_runt_a: assert property ($rose(PREDIV_INPUT_CLOCK)
      |=> PREDIV_INPUT_CLOCK) else $error("runt high pulse");
   pri_no_runt_a: assert property ($fell(PRIMARY_PORT_BITCLK_DIV_CLK)
      |=> !PRIMARY_PORT_BITCLK_DIV_CLK) else $error("runt low pulse");
   ana_no_runt_a: assert property ($rose(ANALOG_RATIO_DIVIDER_CLK)
      |=> $stable(ANALOG_RATIO_DIVIDER_CLK)) else $error("runt high pulse");
   cnv_write_c: cover property (REG_WR && REG_ADDR == 8'h34);
   ana_rise_c: cover property ($rose(ANALOG_RATIO_DIVIDER_CLK));
   pre_rise_c: cover property ($rose(PREDIV_INPUT_CLOCK));
endmodule

bind csm_top csm_monitor u_csm_monitor (.*);

// ==== csm_pkg.sv ====
// Purpose: Types for the clock source select block
// Assumes: Source codes index the sampled source vector
// Notes:   SRC_OFF parks a mux low for reserved selection codes
package csm_pkg;

   typedef enum logic [2:0]
   {
      SRC_PLL   = 3'b000,
      SRC_PRI   = 3'b001,
      SRC_SEC   = 3'b010,
      SRC_CTL   = 3'b011,
      SRC_OSC   = 3'b100,
      SRC_DSP   = 3'b101,
      SRC_DIGNM = 3'b110,
      SRC_OFF   = 3'b111
   } csm_src_e;

   typedef struct packed
   {
      logic [7:0]          reg_pri;
      logic [7:0]          reg_sec;
      logic [7:0]          reg_cnv;
      logic [5:0]          sync1;
      logic [5:0]          sync2;
      csm_src_e [4:0]      act;
      logic [4:0]          parked;
      logic [4:0]          clk_out;
      logic [7:0]          rdata;
   } csm_state_s;

endpackage

// ==== csm_regs.svh ====
// Purpose: Register offsets, field positions and reset values for the
//          clock source select block
// Assumes: 8-bit registers reached through the control port
// Notes:   Masks mark the writable bits; all other bits read as zero
`ifndef CSM_REGS_SVH
`define CSM_REGS_SVH

`define CSM_ADDR_PRI      8'h32
`define CSM_ADDR_SEC      8'h33
`define CSM_ADDR_CNV      8'h34

`define CSM_RST_PRI       8'h00
`define CSM_RST_SEC       8'h00
`define CSM_RST_CNV       8'h10

`define CSM_MASK_PRI      8'hf8
`define CSM_MASK_SEC      8'h70
`define CSM_MASK_CNV      8'hf0

`define CSM_PREDIV_LSB    6
`define CSM_PRIBCLK_LSB   3
`define CSM_SECBCLK_LSB   4
`define CSM_DIGNM_LSB     6
`define CSM_ANANM_LSB     4

`endif

// ==== csm_top.sv ====
// Purpose: Register-controlled clock source muxes for the PLL pre-divider,
//          both bit-clock dividers and the two ratio dividers
// Assumes: Source clocks are slow against CORE_CLK and are sampled
// Notes:   Mux outputs are CORE_CLK-sampled replicas of the chosen source
`timescale 1ns/10ps

`include "csm_regs.svh"

module csm_top
   import csm_pkg::*;
(
   input  wire logic       CORE_CLK,
   input  wire logic       RST_B,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic       REG_WR,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   input  wire logic       PLL_OUT_CLK,
   input  wire logic       PRIMARY_SERIAL_PORT_BITCLK,
   input  wire logic       SECONDARY_SERIAL_PORT_BITCLK,
   input  wire logic       CONTROLLER_CLOCK_INPUT,
   input  wire logic       OSC_CLK,
   input  wire logic       DSP_CLK,
   output logic            PREDIV_INPUT_CLOCK,
   output logic            PRIMARY_PORT_BITCLK_DIV_CLK,
   output logic            SECONDARY_PORT_BITCLK_DIV_CLK,
   output logic            DIGITAL_RATIO_DIVIDER_CLK,
   output logic            ANALOG_RATIO_DIVIDER_CLK
);

   // ****************************************************************
   // Selection decode
   // ****************************************************************
   localparam logic [2:0] MUX_PREDIV = 3'h0;
   localparam logic [2:0] MUX_PRI    = 3'h1;
   localparam logic [2:0] MUX_SEC    = 3'h2;
   localparam logic [2:0] MUX_DIG    = 3'h3;
   localparam logic [2:0] MUX_ANA    = 3'h4;

   // Reserved codes park the output low rather than pass a stray clock
   function automatic csm_src_e sel_src
   (
      input logic [2:0] mux,
      input logic [2:0] code
   );
      csm_src_e src;
      src = SRC_OFF;
      case (mux)
         MUX_PREDIV, MUX_DIG:
         begin
            case (code[1:0])
               2'h0:    src = SRC_PRI;
               2'h1:    src = SRC_SEC;
               2'h2:    src = SRC_CTL;
               default: src = SRC_OSC;
            endcase
         end
         MUX_PRI, MUX_SEC:
         begin
            case (code)
               3'h0:    src = SRC_PLL;
               3'h1:    src = (mux == MUX_SEC) ? SRC_PRI : SRC_OFF;
               3'h2:    src = (mux == MUX_PRI) ? SRC_SEC : SRC_OFF;
               3'h3:    src = SRC_CTL;
               3'h4:    src = SRC_OSC;
               3'h5:    src = SRC_DSP;
               default: src = SRC_OFF;
            endcase
         end
         MUX_ANA:
         begin
            case (code[1:0])
               2'h0, 2'h1: src = SRC_PLL;
               2'h2:       src = SRC_DIGNM;
               default:    src = SRC_PRI;
            endcase
         end
         default: src = SRC_OFF;
      endcase
      return src;
   endfunction

   // ****************************************************************
   // Register port
   // ****************************************************************
   // One address decode serves both the write path and the read mux
   function automatic logic [1:0] reg_index
   (
      input logic [7:0] addr
   );
      logic [1:0] idx;
      idx = 2'h3;
      case (addr)
         `CSM_ADDR_PRI: idx = 2'h0;
         `CSM_ADDR_SEC: idx = 2'h1;
         `CSM_ADDR_CNV: idx = 2'h2;
         default:       idx = 2'h3;
      endcase
      return idx;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   csm_state_s q_r;
   csm_state_s q_nxt;

   logic [7:0]  src_lvl;
   logic [1:0]  reg_sel;
   logic [2:0]  code [5];
   csm_src_e    req;

   always_comb
   begin
      q_nxt = q_r;
      req   = SRC_OFF;

      // Two-stage sampling of every source before any logic looks at it
      // Sources need two CORE_CLK cycles a phase or pulses are lost
      q_nxt.sync1 = {DSP_CLK, OSC_CLK, CONTROLLER_CLOCK_INPUT,
                     SECONDARY_SERIAL_PORT_BITCLK,
                     PRIMARY_SERIAL_PORT_BITCLK, PLL_OUT_CLK};
      q_nxt.sync2 = q_r.sync1;
      // Slot 6 is the digital mux output; slot 7 is tied low for parking
      src_lvl     = {1'b0, q_r.clk_out[MUX_DIG], q_r.sync2};

      // Register writes keep only the selection fields
      reg_sel = reg_index(REG_ADDR);
      if (REG_WR)
      begin
         case (reg_sel)
            2'h0:    q_nxt.reg_pri = REG_WDATA & `CSM_MASK_PRI;
            2'h1:    q_nxt.reg_sec = REG_WDATA & `CSM_MASK_SEC;
            2'h2:    q_nxt.reg_cnv = REG_WDATA & `CSM_MASK_CNV;
            default: q_nxt.reg_pri = q_r.reg_pri;
         endcase
      end

      // Unmapped addresses read zero, like the reserved bits
      case (reg_sel)
         2'h0:    q_nxt.rdata = q_r.reg_pri;
         2'h1:    q_nxt.rdata = q_r.reg_sec;
         2'h2:    q_nxt.rdata = q_r.reg_cnv;
         default: q_nxt.rdata = 8'h00;
      endcase

      code[0] = {1'b0, q_r.reg_pri[`CSM_PREDIV_LSB +: 2]};
      code[1] = q_r.reg_pri[`CSM_PRIBCLK_LSB +: 3];
      code[2] = q_r.reg_sec[`CSM_SECBCLK_LSB +: 3];
      code[3] = {1'b0, q_r.reg_cnv[`CSM_DIGNM_LSB +: 2]};
      code[4] = {1'b0, q_r.reg_cnv[`CSM_ANANM_LSB +: 2]};

      // Break-before-make: finish the old high phase, park low, then
      // join the new source only while it is low, so no runt pulse forms
      // Reserved codes join the tied-low slot and stay quiet
      for (int i = 0; i < 5; i++)
      begin
         req = sel_src(3'(i), code[i]);
         if (q_r.parked[i])
         begin
            q_nxt.clk_out[i] = 1'b0;
            if (!src_lvl[req])
            begin
               q_nxt.act[i]    = req;
               q_nxt.parked[i] = 1'b0;
            end
         end
         else if ((req != q_r.act[i]) && !src_lvl[q_r.act[i]])
         begin
            q_nxt.parked[i]  = 1'b1;
            q_nxt.clk_out[i] = 1'b0;
         end
         else
         begin
            q_nxt.clk_out[i] = src_lvl[q_r.act[i]];
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         q_r         <= '0;
         q_r.reg_pri <= `CSM_RST_PRI;
         q_r.reg_sec <= `CSM_RST_SEC;
         q_r.reg_cnv <= `CSM_RST_CNV;
         // Active sources match the reset codes, so release starts no switch
         q_r.act[0]  <= SRC_PRI;
         q_r.act[1]  <= SRC_PLL;
         q_r.act[2]  <= SRC_PLL;
         q_r.act[3]  <= SRC_PRI;
         q_r.act[4]  <= SRC_PLL;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign REG_RDATA                     = q_r.rdata;
   assign PREDIV_INPUT_CLOCK            = q_r.clk_out[0];
   assign PRIMARY_PORT_BITCLK_DIV_CLK   = q_r.clk_out[1];
   assign SECONDARY_PORT_BITCLK_DIV_CLK = q_r.clk_out[2];
   assign DIGITAL_RATIO_DIVIDER_CLK     = q_r.clk_out[3];
   assign ANALOG_RATIO_DIVIDER_CLK      = q_r.clk_out[4];

endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the clock source select block
// Assumes: Sources are static levels, so every phase is long
// Notes:   The table switches with all sources low; sw switches live
`timescale 1ns/10ps
module testbench;
   logic       CORE_CLK;
   logic       RST_B;
   logic       REG_WR;
   logic [7:0] REG_ADDR;
   logic [7:0] REG_WDATA;
   logic [7:0] REG_RDATA;
   logic [5:0] src;
   logic [4:0] outs;
   int         failures;
   int         checks;
   // Address, data, output index, mask of the source that should pass
   localparam logic [31:0] tbl [28] = '{
      32'h32000002, 32'h32400004, 32'h32800008, 32'h32c00010, 32'h32000101,
      32'h32280120, 32'h32100104, 32'h32180108, 32'h32200110, 32'h32280120,
      32'h32100104, 32'h32000101, 32'h33000201, 32'h33100202, 32'h33500220,
      32'h33300208, 32'h33400210, 32'h33500220, 32'h33100202, 32'h33000201,
      32'h34100302, 32'h34500304, 32'h34900308, 32'h34d00310, 32'h34000401,
      32'h34100401, 32'h34a00408, 32'h34300402};

   csm_top u_csm_top
   (
      .*,
      .PLL_OUT_CLK(src[0]),
      .PRIMARY_SERIAL_PORT_BITCLK(src[1]),
      .SECONDARY_SERIAL_PORT_BITCLK(src[2]),
      .CONTROLLER_CLOCK_INPUT(src[3]),
      .OSC_CLK(src[4]),
      .DSP_CLK(src[5]),
      .PREDIV_INPUT_CLOCK(outs[0]),
      .PRIMARY_PORT_BITCLK_DIV_CLK(outs[1]),
      .SECONDARY_PORT_BITCLK_DIV_CLK(outs[2]),
      .DIGITAL_RATIO_DIVIDER_CLK(outs[3]),
      .ANALOG_RATIO_DIVIDER_CLK(outs[4])
   );

   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge CORE_CLK);
      REG_ADDR  <= a;
      REG_WDATA <= d;
      REG_WR    <= 1'h1;
      @(posedge CORE_CLK);
      REG_WR    <= 1'h0;
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(posedge CORE_CLK);
      REG_ADDR <= a;
      repeat (2) @(posedge CORE_CLK);
      #1 chk($sformatf("reg %h", a), exp, REG_RDATA);
   endtask

   task automatic sw(logic [5:0] s, logic exp);
      @(posedge CORE_CLK);
      src <= s;
      repeat (8) @(posedge CORE_CLK);
      #1 chk("switch prediv", 8'(exp), 8'(outs[0]));
   endtask

   task automatic rst();
      RST_B <= 1'h0;
      repeat (3) @(posedge CORE_CLK);
      RST_B <= 1'h1;
   endtask

   task automatic mux(logic [31:0] e);
      logic [5:0] m;
      int         n;
      string      nm;
      m = e[5:0];
      n = e[10:8];
      nm = $sformatf("mux %0d sel %h", n, e[23:16]);
      @(posedge CORE_CLK);
      src <= 6'h00;
      repeat (8) @(posedge CORE_CLK);
      wr(e[31:24], e[23:16]);
      repeat (8) @(posedge CORE_CLK);
      src <= m;
      repeat (8) @(posedge CORE_CLK);
      #1 chk(nm, 8'(|m), 8'(outs[n]));
      @(posedge CORE_CLK);
      src <= ~m;
      repeat (8) @(posedge CORE_CLK);
      #1 chk(nm, 8'h00, 8'(outs[n]));
   endtask

   initial
   begin
      CORE_CLK = 1'h0;
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end

   initial
   begin
      repeat (3000) @(posedge CORE_CLK);
      failures++;
      summarize();
   end

   initial
   begin
      RST_B = 1'h0;
      REG_WR = 1'h0;
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      src = 6'h00;
      failures = 0;
      checks = 0;
      rst();
      rd(8'h32, 8'h00);
      rd(8'h33, 8'h00);
      rd(8'h34, 8'h10);
      wr(8'h32, 8'he8);
      wr(8'h33, 8'h50);
      wr(8'h34, 8'hf0);
      wr(8'h35, 8'hff);
      rd(8'h32, 8'he8);
      rd(8'h33, 8'h50);
      rd(8'h34, 8'hf0);
      rd(8'h35, 8'h00);
      @(posedge CORE_CLK);
      rst();
      rd(8'h34, 8'h10);
      rd(8'h32, 8'h00);
      $display("test registers done");
      sw(6'h02, 1'h1);
      wr(8'h32, 8'h80);
      sw(6'h02, 1'h1);
      sw(6'h08, 1'h0);
      sw(6'h00, 1'h0);
      sw(6'h08, 1'h1);
      sw(6'h02, 1'h0);
      $display("test switching done");
      foreach (tbl[i])
         mux(tbl[i]);
      $display("test muxes done");
      summarize();
   end
endmodule
